// File: ccr_cmd_channel.sv
// Purpose: card-side byte-wide command channel register window
// Assumes: card core supplies outgoing bytes by index and takes incoming bytes as pulses
// Notes: host strobes are asynchronous and pass the pin sampler first
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - four byte registers, offset 0 data port
// - offset 1: status on read, control on write
// - 16-bit length, low at 2, high at 3
// - decode only the two lowest address lines
// - status bit 7: card has outgoing data
// - status bit 6: card can take block
// - free set when any reset cycle completes
// - status bits 5 to 2 read zero
// - bit 1 write length error, bit 0 read
// - control bits: reset, size read, size write, host
// - two channels share pins, selected by enable
// - reset command resets only this interface
// - write transfer: first byte busy, error till last
// - read transfer: first read clears available, error till last
// - length bytes accessible in either order
module ccr_cmd_channel
    import ccr_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic host_chan_sel_n_in,
    input wire logic host_io_space_n_in,
    input wire logic [1:0] host_addr_in,
    input wire logic host_rd_n_in,
    input wire logic host_wr_n_in,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe_out,
    input wire logic card_avail_in,
    input wire logic [15:0] card_avail_len_in,
    input wire logic card_free_in,
    input wire logic [7:0] card_tx_byte_in,
    output logic [15:0] card_tx_index_out,
    output logic [7:0] card_rx_byte_out,
    output logic card_rx_valid_out,
    output logic [15:0] xfer_len_out,
    output logic host_control_cmd_out,
    output logic size_read_cmd_out,
    output logic size_write_cmd_out,
    output logic iface_reset_out
);
    ccr_host_if host ();

    ccr_pin_sync u_sync (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .chan_sel_n_in(host_chan_sel_n_in),
        .io_space_n_in(host_io_space_n_in),
        .addr_in(host_addr_in),
        .rd_n_in(host_rd_n_in),
        .wr_n_in(host_wr_n_in),
        .data_in(host_data_in),
        .host(host)
    );

    ccr_state_t st_ff;
    ccr_state_t nxt_st;
    logic data_available_flag_ff;
    logic free_flag_ff;
    logic write_error_flag_ff;
    logic read_error_flag_ff;
    logic [15:0] len_ff;
    logic [15:0] wr_cnt_ff;
    logic [15:0] rd_cnt_ff;
    logic host_control_cmd_ff;
    logic size_read_cmd_ff;
    logic size_write_cmd_ff;
    logic iface_reset_ff;
    logic [7:0] rx_byte_ff;
    logic rx_valid_ff;
    logic [7:0] rdata_ff;
    logic oe_ff;

    logic nxt_avail;
    logic nxt_free;
    logic nxt_werr;
    logic nxt_rerr;
    logic [15:0] nxt_len;
    logic [15:0] nxt_wr_cnt;
    logic [15:0] nxt_rd_cnt;
    logic nxt_hc;
    logic nxt_sr;
    logic nxt_sw;
    logic nxt_ireset;
    logic [7:0] nxt_rx_byte;
    logic nxt_rx_valid;
    logic [7:0] nxt_rdata;
    logic nxt_oe;

    logic wr_data;
    logic wr_ctrl;
    logic wr_len_lo;
    logic wr_len_hi;
    logic rd_data;
    logic soft_reset;
    logic in_run;
    logic [15:0] wr_cnt_inc;
    logic [15:0] rd_cnt_inc;
    logic [7:0] status_byte;

    always_comb begin
        wr_data = host.wr_pulse && host.addr == CCR_OFS_DATA;
        wr_ctrl = host.wr_pulse && host.addr == CCR_OFS_CTRL_STAT;
        wr_len_lo = host.wr_pulse && host.addr == CCR_OFS_LEN_LOW;
        wr_len_hi = host.wr_pulse && host.addr == CCR_OFS_LEN_HIGH;
        rd_data = host.rd_pulse && host.addr == CCR_OFS_DATA;
        soft_reset = wr_ctrl && host.wdata[CCR_CMD_RESET_BIT];
        // host accesses landing in the one-cycle init state are dropped
        in_run = st_ff == CCR_ST_RUN;
        // counters saturate so a runaway host keeps the error flag up
        wr_cnt_inc = (wr_cnt_ff == CCR_CNT_MAX) ? wr_cnt_ff : wr_cnt_ff + CCR_CNT_ONE;
        rd_cnt_inc = (rd_cnt_ff == CCR_CNT_MAX) ? rd_cnt_ff : rd_cnt_ff + CCR_CNT_ONE;
        status_byte = CCR_BYTE_ZERO;
        status_byte[CCR_STAT_AVAIL_BIT] = data_available_flag_ff;
        status_byte[CCR_STAT_FREE_BIT] = free_flag_ff;
        status_byte[CCR_STAT_WERR_BIT] = write_error_flag_ff;
        status_byte[CCR_STAT_RERR_BIT] = read_error_flag_ff;
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_avail = data_available_flag_ff;
        nxt_free = free_flag_ff;
        nxt_werr = write_error_flag_ff;
        nxt_rerr = read_error_flag_ff;
        nxt_len = len_ff;
        nxt_wr_cnt = wr_cnt_ff;
        nxt_rd_cnt = rd_cnt_ff;
        unique case (st_ff)
            CCR_ST_INIT: begin
                // one cycle after the clear, so free never rises with stale flags
                nxt_free = 1'b1;
                nxt_st = CCR_ST_RUN;
            end
            CCR_ST_RUN: begin
                if (soft_reset) begin
                    nxt_avail = 1'b0;
                    nxt_free = 1'b0;
                    nxt_werr = 1'b0;
                    nxt_rerr = 1'b0;
                    nxt_wr_cnt = CCR_LEN_RESET;
                    nxt_rd_cnt = CCR_LEN_RESET;
                    nxt_st = CCR_ST_INIT;
                end else begin
                    if (wr_len_lo) begin
                        nxt_len[7:0] = host.wdata;
                        nxt_wr_cnt = CCR_LEN_RESET;
                    end
                    if (wr_len_hi) begin
                        nxt_len[15:8] = host.wdata;
                        nxt_wr_cnt = CCR_LEN_RESET;
                    end
                    if (wr_data) begin
                        nxt_wr_cnt = wr_cnt_inc;
                        nxt_free = 1'b0;
                        // error stands until the count meets the length exactly
                        nxt_werr = (wr_cnt_inc != len_ff);
                    end
                    if (rd_data) begin
                        nxt_rd_cnt = rd_cnt_inc;
                        nxt_avail = 1'b0;
                        nxt_rerr = (rd_cnt_inc != len_ff);
                    end
                    // card events win over the host data-access clears in the same cycle
                    if (card_free_in) begin
                        nxt_free = 1'b1;
                    end
                end
            end
            default: begin
                nxt_st = CCR_ST_INIT;
            end
        endcase
        // a card block is never dropped, even in a soft reset or init cycle, or the card would stall
        if (card_avail_in) begin
            nxt_avail = 1'b1;
            nxt_len = card_avail_len_in;
            nxt_rd_cnt = CCR_LEN_RESET;
        end
    end

    always_comb begin
        unique case (host.addr)
            CCR_OFS_DATA: nxt_rdata = card_tx_byte_in;
            CCR_OFS_CTRL_STAT: nxt_rdata = status_byte;
            CCR_OFS_LEN_LOW: nxt_rdata = len_ff[7:0];
            CCR_OFS_LEN_HIGH: nxt_rdata = len_ff[15:8];
        endcase
        nxt_oe = host.rd_active;
    end

    // hardware reset enters the init state, so free rises one cycle after release
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            st_ff <= CCR_ST_INIT;
            data_available_flag_ff <= 1'b0;
            free_flag_ff <= 1'b0;
            write_error_flag_ff <= 1'b0;
            read_error_flag_ff <= 1'b0;
            len_ff <= CCR_LEN_RESET;
            wr_cnt_ff <= CCR_LEN_RESET;
            rd_cnt_ff <= CCR_LEN_RESET;
        end else begin
            st_ff <= nxt_st;
            data_available_flag_ff <= nxt_avail;
            free_flag_ff <= nxt_free;
            write_error_flag_ff <= nxt_werr;
            read_error_flag_ff <= nxt_rerr;
            len_ff <= nxt_len;
            wr_cnt_ff <= nxt_wr_cnt;
            rd_cnt_ff <= nxt_rd_cnt;
        end
    end

    // command bits: a reset write clears them and loads none of its other bits
    always_comb begin
        nxt_hc = host_control_cmd_ff;
        nxt_sr = size_read_cmd_ff;
        nxt_sw = size_write_cmd_ff;
        nxt_ireset = 1'b0;
        if (in_run && soft_reset) begin
            nxt_hc = 1'b0;
            nxt_sr = 1'b0;
            nxt_sw = 1'b0;
            nxt_ireset = 1'b1;
        end else if (in_run && wr_ctrl) begin
            nxt_hc = host.wdata[CCR_CMD_HOST_CTL_BIT];
            nxt_sw = host.wdata[CCR_CMD_SIZE_WR_BIT];
            nxt_sr = host.wdata[CCR_CMD_SIZE_RD_BIT];
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            host_control_cmd_ff <= 1'b0;
            size_read_cmd_ff <= 1'b0;
            size_write_cmd_ff <= 1'b0;
            iface_reset_ff <= 1'b0;
        end else begin
            host_control_cmd_ff <= nxt_hc;
            size_read_cmd_ff <= nxt_sr;
            size_write_cmd_ff <= nxt_sw;
            iface_reset_ff <= nxt_ireset;
        end
    end

    // the card sees each host data byte once, as a one-cycle pulse
    always_comb begin
        nxt_rx_byte = rx_byte_ff;
        nxt_rx_valid = 1'b0;
        if (in_run && wr_data) begin
            nxt_rx_byte = host.wdata;
            nxt_rx_valid = 1'b1;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_byte_ff <= CCR_BYTE_ZERO;
            rx_valid_ff <= 1'b0;
        end else begin
            rx_byte_ff <= nxt_rx_byte;
            rx_valid_ff <= nxt_rx_valid;
        end
    end

    // read path registered on its own; drive follows only the synced strobe
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_ff <= CCR_BYTE_ZERO;
            oe_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            oe_ff <= nxt_oe;
        end
    end

    assign host_data_out = rdata_ff;
    assign host_data_oe_out = oe_ff;
    assign card_tx_index_out = rd_cnt_ff;
    assign card_rx_byte_out = rx_byte_ff;
    assign card_rx_valid_out = rx_valid_ff;
    assign xfer_len_out = len_ff;
    assign host_control_cmd_out = host_control_cmd_ff;
    assign size_read_cmd_out = size_read_cmd_ff;
    assign size_write_cmd_out = size_write_cmd_ff;
    assign iface_reset_out = iface_reset_ff;
endmodule // ccr_cmd_channel
`default_nettype wire

// File: ccr_cmd_channel_bench.sv
// Purpose: self-checking bench for the command channel
// Assumes: card core modelled by the bench, host by ccr_host_model
// Notes: lengths kept short so extra-byte errors are reached quickly
`timescale 1ns/1ps
`default_nettype none
module ccr_cmd_channel_bench
    import ccr_pkg::*;
;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic avail = 1'b0;
    logic free = 1'b0;
    logic [15:0] avail_len = 16'h0000;
    wire logic sel_n, io_n, rd_n, wr_n, oe, rx_valid, hc, sr, sw, irst;
    wire logic [1:0] addr;
    wire logic [7:0] hdrv, dout, rx_byte;
    wire logic [15:0] tx_idx, xlen;
    wire logic [7:0] bus_w = oe ? dout : hdrv;
    wire logic [7:0] tx_byte = tx_idx[7:0] ^ 8'hA5;
    int n_mismatch = 0;
    int n_compared = 0;
    int n_rst = 0;
    logic [7:0] last_rx = 8'h00;
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        if (rx_valid === 1'b1) last_rx <= rx_byte;
        if (irst === 1'b1) n_rst++;
    end
    ccr_host_model ccr_host_model_inst (.mclk_in(mclk), .oe_in(oe), .rdata_in(bus_w),
        .chan_sel_n_out(sel_n), .io_space_n_out(io_n), .addr_out(addr), .rd_n_out(rd_n),
        .wr_n_out(wr_n), .data_out(hdrv));
    ccr_cmd_channel ccr_cmd_channel_inst (.mclk_in(mclk), .rst_in(rst),
        .host_chan_sel_n_in(sel_n), .host_io_space_n_in(io_n), .host_addr_in(addr),
        .host_rd_n_in(rd_n), .host_wr_n_in(wr_n), .host_data_in(bus_w), .host_data_out(dout),
        .host_data_oe_out(oe), .card_avail_in(avail), .card_avail_len_in(avail_len),
        .card_free_in(free), .card_tx_byte_in(tx_byte), .card_tx_index_out(tx_idx),
        .card_rx_byte_out(rx_byte), .card_rx_valid_out(rx_valid), .xfer_len_out(xlen),
        .host_control_cmd_out(hc), .size_read_cmd_out(sr), .size_write_cmd_out(sw),
        .iface_reset_out(irst));
    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hw(input logic [1:0] a, input logic [7:0] d, input logic sel_n = 1'b0);
        logic [7:0] q;
        logic ok;
        ccr_host_model_inst.access(a, d, 1'b1, sel_n, q, ok);
    endtask
    task automatic hr(input logic [1:0] a, output logic [7:0] q);
        logic ok;
        ccr_host_model_inst.access(a, 8'h00, 1'b0, 1'b0, q, ok);
        if (!ok) begin
            n_mismatch++;
            $display("[FAIL] %0t no read drive", $time);
            results();
        end
    endtask
    function automatic logic [15:0] st(input logic av, fr, we, re);
        return {8'h00, av, fr, 4'h0, we, re};
    endfunction
    function automatic logic [15:0] txb(input int i);
        return {8'h00, 8'(i) ^ 8'hA5};
    endfunction
    task automatic pulse(input logic is_avail);
        @(posedge mclk);
        if (is_avail) avail <= 1'b1;
        else free <= 1'b1;
        @(posedge mclk);
        avail <= 1'b0;
        free <= 1'b0;
    endtask
    initial begin
        logic [7:0] q, d;
        logic [15:0] len;
        void'($urandom(32'h9016));
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        repeat (8) @(posedge mclk);
        hr(CCR_OFS_CTRL_STAT, q);
        cmp({8'h00, q}, st(0, 1, 0, 0));
        for (int b = 0; b < 3; b++) begin
            hw(CCR_OFS_CTRL_STAT, 8'h01 << b);
            cmp({13'h0, sr, sw, hc}, 16'h0001 << b);
            hr(CCR_OFS_CTRL_STAT, q);
            cmp({8'h00, q}, st(0, 1, 0, 0));
        end
        len = 16'($urandom_range(5, 2));
        hw(CCR_OFS_LEN_HIGH, len[15:8]);
        hw(CCR_OFS_LEN_LOW, len[7:0]);
        hw(CCR_OFS_LEN_LOW, 8'($urandom()), 1'b1);
        cmp(xlen, len);
        hr(CCR_OFS_LEN_HIGH, q);
        cmp({8'h00, q}, {8'h00, len[15:8]});
        hr(CCR_OFS_LEN_LOW, q);
        cmp({8'h00, q}, {8'h00, len[7:0]});
        hw(CCR_OFS_CTRL_STAT, 8'h01);
        for (int i = 0; i <= int'(len); i++) begin
            d = 8'($urandom());
            hw(CCR_OFS_DATA, d);
            cmp({8'h00, last_rx}, {8'h00, d});
            hr(CCR_OFS_CTRL_STAT, q);
            cmp({8'h00, q}, st(0, 0, i + 1 != int'(len), 0));
        end
        hw(CCR_OFS_CTRL_STAT, 8'h00);
        pulse(1'b0);
        hr(CCR_OFS_CTRL_STAT, q);
        cmp({8'h00, q}, st(0, 1, 1, 0));
        len = 16'($urandom_range(4, 2));
        avail_len <= len;
        pulse(1'b1);
        hr(CCR_OFS_CTRL_STAT, q);
        cmp({8'h00, q}, st(1, 1, 1, 0));
        hr(CCR_OFS_LEN_LOW, q);
        cmp({8'h00, q}, {8'h00, len[7:0]});
        for (int i = 0; i <= int'(len); i++) begin
            hr(CCR_OFS_DATA, q);
            cmp({8'h00, q}, txb(i));
            hr(CCR_OFS_CTRL_STAT, q);
            cmp({8'h00, q}, st(0, 1, 1, i + 1 != int'(len)));
        end
        len = 16'($urandom());
        hw(CCR_OFS_LEN_LOW, len[7:0]);
        hw(CCR_OFS_LEN_HIGH, len[15:8]);
        cmp(xlen, len);
        hr(CCR_OFS_LEN_HIGH, q);
        cmp({8'h00, q}, {8'h00, len[15:8]});
        hw(CCR_OFS_CTRL_STAT, 8'h01);
        hw(CCR_OFS_CTRL_STAT, 8'h08);
        cmp(16'(n_rst), 16'h0001);
        cmp({15'h0, hc}, 16'h0000);
        hr(CCR_OFS_CTRL_STAT, q);
        cmp({8'h00, q}, st(0, 1, 0, 0));
        cmp(xlen, len);
        hw(CCR_OFS_CTRL_STAT, 8'h04);
        pulse(1'b1);
        rst <= 1'b1;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        repeat (8) @(posedge mclk);
        hr(CCR_OFS_CTRL_STAT, q);
        cmp({8'h00, q}, st(0, 1, 0, 0));
        cmp({15'h0, sr}, 16'h0000);
        results();
    end
endmodule // ccr_cmd_channel_bench
`default_nettype wire

// File: ccr_cmd_channel_sva.sv
// Purpose: port checks for the command channel register window
// Assumes: host keeps each strobe level for at least three cycles
// Notes: bound onto the design top at the foot
`timescale 1ns/1ps
`default_nettype none
module ccr_cmd_channel_sva
    import ccr_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic host_chan_sel_n_in,
    input wire logic host_io_space_n_in,
    input wire logic [1:0] host_addr_in,
    input wire logic host_rd_n_in,
    input wire logic host_wr_n_in,
    input wire logic [7:0] host_data_out,
    input wire logic host_data_oe_out,
    input wire logic card_avail_in,
    input wire logic [15:0] card_tx_index_out,
    input wire logic card_rx_valid_out,
    input wire logic [15:0] xfer_len_out,
    input wire logic host_control_cmd_out,
    input wire logic size_read_cmd_out,
    input wire logic size_write_cmd_out,
    input wire logic iface_reset_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    wire logic sel_w = !host_chan_sel_n_in && !host_io_space_n_in;
    oe_read_a: assert property ((sel_w && !host_rd_n_in)[*5] |-> host_data_oe_out)
        else $error("read strobe left bus undriven");
    oe_idle_a: assert property (host_rd_n_in[*5] |-> !host_data_oe_out)
        else $error("bus driven without read strobe");
    stat_rsvd_a: assert property ((host_addr_in == CCR_OFS_CTRL_STAT)[*6] ##0 host_data_oe_out
        |-> host_data_out[5:2] == 4'h0)
        else $error("reserved status bits not zero");
    rx_pulse_a: assert property (card_rx_valid_out |=> !card_rx_valid_out)
        else $error("received byte pulse too long");
    rx_after_wr_a: assert property (card_rx_valid_out
        |-> $past(host_wr_n_in, 2) && !$past(host_wr_n_in, 6))
        else $error("received byte without write strobe");
    soft_rst_a: assert property (iface_reset_out |=> !iface_reset_out && !host_control_cmd_out
        && !size_read_cmd_out && !size_write_cmd_out)
        else $error("command bits survive interface reset");
    len_hold_a: assert property ((host_wr_n_in && !card_avail_in)[*8] |=> $stable(xfer_len_out))
        else $error("length changed without cause");
    idx_clear_a: assert property (card_avail_in |=> card_tx_index_out == 16'h0000)
        else $error("read index not cleared by new block");
endmodule // ccr_cmd_channel_sva
bind ccr_cmd_channel ccr_cmd_channel_sva ccr_cmd_channel_sva_inst (
    .mclk_in(mclk_in), .rst_in(rst_in), .host_chan_sel_n_in(host_chan_sel_n_in),
    .host_io_space_n_in(host_io_space_n_in), .host_addr_in(host_addr_in),
    .host_rd_n_in(host_rd_n_in), .host_wr_n_in(host_wr_n_in), .host_data_out(host_data_out),
    .host_data_oe_out(host_data_oe_out), .card_avail_in(card_avail_in),
    .card_tx_index_out(card_tx_index_out), .card_rx_valid_out(card_rx_valid_out),
    .xfer_len_out(xfer_len_out), .host_control_cmd_out(host_control_cmd_out),
    .size_read_cmd_out(size_read_cmd_out), .size_write_cmd_out(size_write_cmd_out),
    .iface_reset_out(iface_reset_out));
`default_nettype wire

// File: ccr_host_if.sv
// Purpose: synchronised host access events between pin sampler and register core
// Assumes: single clock domain after the sampler
// Notes: pulses are one cycle wide
`timescale 1ns/1ps
`default_nettype none
interface ccr_host_if;
    logic rd_pulse;
    logic wr_pulse;
    logic rd_active;
    logic [1:0] addr;
    logic [7:0] wdata;
    modport sampler (output rd_pulse, output wr_pulse, output rd_active,
        output addr, output wdata);
    modport core (input rd_pulse, input wr_pulse, input rd_active,
        input addr, input wdata);
endinterface
`default_nettype wire

// File: ccr_host_model.sv
// Purpose: host processor driving the card parallel port
// Assumes: strobes held eight cycles, well above the three-cycle minimum
// Notes: released data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module ccr_host_model (
    input wire logic mclk_in,
    input wire logic oe_in,
    input wire logic [7:0] rdata_in,
    output logic chan_sel_n_out,
    output logic io_space_n_out,
    output logic [1:0] addr_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic [7:0] data_out
);
    initial begin
        chan_sel_n_out = 1'b1;
        io_space_n_out = 1'b1;
        addr_out = 2'h0;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        data_out = 8'h00;
    end
    task automatic access(input logic [1:0] a, input logic [7:0] d, input logic wr,
        input logic sel_n, output logic [7:0] q, output logic ok);
        @(posedge mclk_in);
        chan_sel_n_out <= sel_n;
        io_space_n_out <= 1'b0;
        addr_out <= a;
        data_out <= d;
        @(posedge mclk_in);
        rd_n_out <= wr;
        wr_n_out <= !wr;
        repeat (8) @(posedge mclk_in);
        ok = wr || sel_n || (oe_in === 1'b1);
        q = rdata_in;
        rd_n_out <= 1'b1;
        wr_n_out <= 1'b1;
        repeat (3) @(posedge mclk_in);
        chan_sel_n_out <= 1'b1;
        io_space_n_out <= 1'b1;
        addr_out <= ~a;
        data_out <= ~d;
        repeat (4) @(posedge mclk_in);
    endtask
endmodule // ccr_host_model
`default_nettype wire

// File: ccr_pin_sync.sv
// Purpose: bring asynchronous host strobes, address and data into mclk domain
// Assumes: host holds address and data stable around the strobe end
// Notes: accesses are taken at the trailing edge of each strobe
`timescale 1ns/1ps
`default_nettype none
module ccr_pin_sync
    import ccr_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic chan_sel_n_in,
    input wire logic io_space_n_in,
    input wire logic [1:0] addr_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic [7:0] data_in,
    ccr_host_if.sampler host
);
    logic [CCR_SYNC_W-1:0] meta_ff;
    logic [CCR_SYNC_W-1:0] sync_ff;
    logic rd_prev_ff;
    logic wr_prev_ff;
    logic [CCR_SYNC_W-1:0] nxt_meta;
    logic sel;
    logic rd_now;
    logic wr_now;

    always_comb begin
        nxt_meta = {chan_sel_n_in, io_space_n_in, rd_n_in, wr_n_in, addr_in, data_in};
        // this channel's enable and the I/O space line together select us; higher address bits never arrive
        sel = ~sync_ff[13] & ~sync_ff[12];
        rd_now = sel & ~sync_ff[11];
        wr_now = sel & ~sync_ff[10];
    end

    // strobes idle high, so reset to the inactive level
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_ff <= {4'hF, 2'h0, 8'h00};
            sync_ff <= {4'hF, 2'h0, 8'h00};
            rd_prev_ff <= 1'b0;
            wr_prev_ff <= 1'b0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= meta_ff;
            rd_prev_ff <= rd_now;
            wr_prev_ff <= wr_now;
        end
    end

    assign host.rd_active = rd_now;
    assign host.rd_pulse = rd_prev_ff & ~rd_now;
    assign host.wr_pulse = wr_prev_ff & ~wr_now;
    assign host.addr = sync_ff[9:8];
    assign host.wdata = sync_ff[7:0];
endmodule // ccr_pin_sync
`default_nettype wire

// File: ccr_pkg.sv
// Purpose: shared constants for the card command channel register window
// Assumes: byte-wide host port, two address lines decoded
// Notes: register offsets, status and command bit positions and byte and length reset values live here
package ccr_pkg;
    localparam logic [1:0] CCR_OFS_DATA = 2'h0;
    localparam logic [1:0] CCR_OFS_CTRL_STAT = 2'h1;
    localparam logic [1:0] CCR_OFS_LEN_LOW = 2'h2;
    localparam logic [1:0] CCR_OFS_LEN_HIGH = 2'h3;

    localparam int CCR_STAT_AVAIL_BIT = 7;
    localparam int CCR_STAT_FREE_BIT = 6;
    localparam int CCR_STAT_WERR_BIT = 1;
    localparam int CCR_STAT_RERR_BIT = 0;

    localparam int CCR_CMD_RESET_BIT = 3;
    localparam int CCR_CMD_SIZE_RD_BIT = 2;
    localparam int CCR_CMD_SIZE_WR_BIT = 1;
    localparam int CCR_CMD_HOST_CTL_BIT = 0;

    localparam int CCR_SYNC_W = 14;
    localparam logic [7:0] CCR_BYTE_ZERO = 8'h00;
    localparam logic [15:0] CCR_LEN_RESET = 16'h0000;
    localparam logic [15:0] CCR_CNT_ONE = 16'h0001;
    localparam logic [15:0] CCR_CNT_MAX = 16'hFFFF;

    typedef enum logic [1:0] {
        CCR_ST_RUN = 2'b01,
        CCR_ST_INIT = 2'b10
    } ccr_state_t;
endpackage
